// ==== hdl/ttcs_pkg.sv ====
/*
  Constants of the tone transceiver control and status block: register
  select codes, control and status bit positions, reset values and burst
  timing. Assumes a single 125 MHz clock.
*/
`default_nettype none

package ttcs_pkg;

  // Register select line and read/write line codes
  localparam logic       SEL_DATA     = 1'h0;
  localparam logic       SEL_CONTROL  = 1'h1;
  localparam logic       DIR_WRITE    = 1'h0;
  localparam logic       DIR_READ     = 1'h1;

  // Primary control bit positions
  localparam int         PC_TONE_OUT  = 0;
  localparam int         PC_FILTER    = 1;
  localparam int         PC_IRQ_EN    = 2;
  localparam int         PC_REDIRECT  = 3;

  // Secondary control bit positions
  localparam int         SC_BURST_OFF = 0;
  localparam int         SC_DIAG      = 1;
  localparam int         SC_SINGLE    = 2;
  localparam int         SC_COLUMN    = 3;

  // Status bit positions
  localparam int         ST_IRQ       = 0;
  localparam int         ST_TX_EMPTY  = 1;
  localparam int         ST_RX_FULL   = 2;
  localparam int         ST_STEER     = 3;

  // Reset values
  localparam logic [3:0] CTRL_RESET   = 4'h0;
  localparam logic [3:0] DATA_RESET   = 4'h0;

  // Burst and pause duration in normal tone mode: half of the doubled 102 ms
  localparam int         CLK_FREQ_HZ  = 125_000_000;
  localparam int         BURST_TIME_US = 51_000;
  localparam int         BURST_CYCLES_DFLT = BURST_TIME_US * (CLK_FREQ_HZ / 1_000_000);

endpackage : ttcs_pkg

`default_nettype wire

// ==== hdl/ttcs_status_flag.sv ====
/*
  One sticky status flag that clears on a completed status read.
  Assumes snap marks the start of a status read and clr its completion.
*/
`timescale 1ns/100ps
`default_nettype none

module ttcs_status_flag (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic set,
  input  wire logic snap,
  input  wire logic clr,
  input  wire logic hold,
  output var  logic q
);

  logic fresh;

  // Set wins over clear; an event after the snapshot survives the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      q     <= 1'b0;
      fresh <= 1'b0;
    end else begin
      if (hold)
        q <= 1'b0;
      else if (set)
        q <= 1'b1;
      else if (clr)
        q <= fresh;
      if (hold)
        fresh <= 1'b0;
      else if (set)
        fresh <= 1'b1;
      else if (snap || clr)
        fresh <= 1'b0;
    end
  end

endmodule // ttcs_status_flag

`default_nettype wire

// ==== hdl/ttcs_burst_timer.sv ====
/*
  Tone burst sequencer: a burst of fixed length, then a pause of the same
  length, then a one-cycle done pulse. Assumes start arrives only in burst mode.
*/
`timescale 1ns/100ps
`default_nettype none

module ttcs_burst_timer
  import ttcs_pkg::*;
#(
  parameter int CYCLES = BURST_CYCLES_DFLT
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic start,
  input  wire logic double_len,
  output var  logic tone_phase,
  output var  logic busy,
  output var  logic done
);

  localparam int CW = $clog2(2 * CYCLES + 1);

  generate
    if (CYCLES < 1) begin : g_bad_len
      $error("burst length must be at least one cycle");
    end
  endgenerate

  typedef enum logic [2:0] {
    TTCS_IDLE  = 3'b001,
    TTCS_TONE  = 3'b010,
    TTCS_PAUSE = 3'b100
  } ttcs_burst_e;

  ttcs_burst_e   state;
  logic [CW-1:0] cnt;
  wire  [CW-1:0] len_short = CW'(CYCLES - 1);
  wire  [CW-1:0] len_long  = CW'(2 * CYCLES - 1);
  wire  [CW-1:0] len       = double_len ? len_long : len_short;
  wire           cnt_zero  = (cnt == '0);

  assign tone_phase = (state == TTCS_TONE);
  assign busy       = (state != TTCS_IDLE);

  // Burst, then equal pause, then done; writes while busy are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= TTCS_IDLE;
      cnt   <= '0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        TTCS_IDLE: if (start) begin
          state <= TTCS_TONE;
          cnt   <= len;
        end
        TTCS_TONE: if (cnt_zero) begin
          state <= TTCS_PAUSE;
          cnt   <= len;
        end else begin
          cnt <= cnt - 1'b1;
        end
        TTCS_PAUSE: if (cnt_zero) begin
          state <= TTCS_IDLE;
          done  <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
        default: state <= TTCS_IDLE;
      endcase
    end
  end

endmodule // ttcs_burst_timer

`default_nettype wire

// ==== hdl/ttcs_top.sv ====
/*
  Host-visible control and status logic of a dual-tone signalling
  transceiver: the parallel register port, both control registers, the
  status register and the shared event pin. Assumes the bus pins are
  asynchronous to clk and the receiver signals come from logic on clk.
*/
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Burst mode: fixed burst, equal pause
// - After pause: set empty flag, interrupt
// - Filter mode doubles burst and pause
// - Non-burst: tone follows host enable
// - Diagnostic mode: inverted steering on pin
// - Bit 2 picks dual or single tone
// - Bit 3 picks row or column tone in single tone mode
// - Interrupt flag follows empty or full
// - Empty flag: pause end, read, non-burst
// - Full flag set by valid received data
// - Steering flag tracks tone absence, no read-clear
// - Select and direction lines pick register
// - Redirect bit sends next write secondary
// - Pin low on receive or transmit ready if enabled, outside filter and diagnostic modes
module ttcs_top
  import ttcs_pkg::*;
#(
  parameter int BURST_CYCLES = BURST_CYCLES_DFLT
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       chip_select_n,
  input  wire logic       register_select_line,
  input  wire logic       read_write,
  input  wire logic [3:0] data_in,
  output var  logic [3:0] data_out,
  output var  logic       data_out_enable_n,
  input  wire logic       rx_valid,
  input  wire logic [3:0] rx_code,
  input  wire logic       rx_steer_delayed,
  input  wire logic       call_progress_tone,
  output var  logic       event_tone_pin_out,
  output var  logic       event_tone_pin_oe_n,
  output var  logic       tone_on,
  output var  logic [3:0] tx_code,
  output var  logic       filter_mode_select,
  output var  logic       single_tone_select,
  output var  logic       high_group_select
);

  // Bus pin synchronisers: chip select, select, direction, data
  logic [6:0] bus_s1;
  logic [6:0] bus_s2;
  logic       cs_prev;

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_s1  <= 7'h7F;
      bus_s2  <= 7'h7F;
      cs_prev <= 1'b1;
    end else begin
      bus_s1  <= {chip_select_n, register_select_line, read_write, data_in};
      bus_s2  <= bus_s1;
      cs_prev <= bus_s2[6];
    end
  end

  wire       cs_n_s  = bus_s2[6];
  wire       rs_s    = bus_s2[5];
  wire       rw_s    = bus_s2[4];
  wire [3:0] data_s  = bus_s2[3:0];
  wire       acc_beg = !cs_n_s && cs_prev;   // Cycle opens
  wire       acc_end = cs_n_s && !cs_prev;   // Cycle completes

  // Access attributes held for the whole cycle
  logic       acc_rs;
  logic       acc_rw;
  logic       acc_on;
  logic [3:0] wr_data;

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_rs  <= SEL_DATA;
      acc_rw  <= DIR_READ;
      acc_on  <= 1'b0;
      wr_data <= DATA_RESET;
    end else begin
      if (acc_beg) begin
        acc_rs <= rs_s;
        acc_rw <= rw_s;
      end
      acc_on <= !cs_n_s;
      if (!cs_n_s)
        wr_data <= data_s;    // Last value seen while selected
    end
  end

  // Register decode; writes act at cycle end so data has settled
  wire wr_tx     = acc_end && acc_rs == SEL_DATA && acc_rw == DIR_WRITE;
  wire wr_ctl    = acc_end && acc_rs == SEL_CONTROL && acc_rw == DIR_WRITE;
  wire rd_rx_beg = acc_beg && rs_s == SEL_DATA && rw_s == DIR_READ;
  wire rd_st_beg = acc_beg && rs_s == SEL_CONTROL && rw_s == DIR_READ;
  wire rd_st_end = acc_end && acc_rs == SEL_CONTROL && acc_rw == DIR_READ;

  // Control registers sharing one address
  logic [3:0] primary_control;
  logic [3:0] secondary_control;
  logic       redirect_pend;

  always_ff @(posedge clk) begin
    if (reset) begin
      primary_control   <= CTRL_RESET;
      secondary_control <= CTRL_RESET;
      redirect_pend     <= 1'b0;
    end else if (wr_ctl) begin
      if (redirect_pend) begin
        secondary_control <= wr_data;
        redirect_pend     <= 1'b0;
      end else begin
        primary_control <= wr_data;
        redirect_pend   <= wr_data[PC_REDIRECT];
      end
    end
  end

  wire burst_mode = !secondary_control[SC_BURST_OFF];
  wire cp_mode    = primary_control[PC_FILTER];
  wire irq_en     = primary_control[PC_IRQ_EN];
  wire diag_mode  = secondary_control[SC_DIAG];

  assign filter_mode_select = cp_mode;
  assign single_tone_select = secondary_control[SC_SINGLE];
  assign high_group_select  = secondary_control[SC_SINGLE] && secondary_control[SC_COLUMN];

  // Transmit code; writes land even while a burst runs, timing is not restarted
  always_ff @(posedge clk) begin
    if (reset)
      tx_code <= DATA_RESET;
    else if (wr_tx)
      tx_code <= wr_data;
  end

  // Burst sequencing
  logic tmr_tone;
  logic tmr_busy;
  logic tmr_done;

  ttcs_burst_timer #(
    .CYCLES(BURST_CYCLES)
  ) u_burst (
    .clk       (clk),
    .reset     (reset),
    .start     (wr_tx && burst_mode),
    .double_len(cp_mode),
    .tone_phase(tmr_tone),
    .busy      (tmr_busy),
    .done      (tmr_done)
  );

  // Tone output: timed in burst mode, host-held otherwise
  wire next_tone_on = primary_control[PC_TONE_OUT] && (burst_mode ? tmr_tone : 1'b1);

  always_ff @(posedge clk) begin
    if (reset)
      tone_on <= 1'b0;
    else
      tone_on <= next_tone_on;
  end

  // Status flags; a flag cleared by a read only clears once the read ends
  logic stat_irq;
  logic stat_txe;
  logic stat_rxf;
  logic stat_steer;
  logic steer_prev;
  wire  txe_set = tmr_done && burst_mode;

  ttcs_status_flag u_flag_txe (
    .clk  (clk),
    .reset(reset),
    .set  (txe_set),
    .snap (rd_st_beg),
    .clr  (rd_st_end),
    .hold (!burst_mode),
    .q    (stat_txe)
  );

  ttcs_status_flag u_flag_rxf (
    .clk  (clk),
    .reset(reset),
    .set  (rx_valid),
    .snap (rd_st_beg),
    .clr  (rd_st_end),
    .hold (1'b0),
    .q    (stat_rxf)
  );

  ttcs_status_flag u_flag_irq (
    .clk  (clk),
    .reset(reset),
    .set  (txe_set || rx_valid),
    .snap (rd_st_beg),
    .clr  (rd_st_end),
    .hold (1'b0),
    .q    (stat_irq)
  );

  // Steering flag follows edges only, so a status read leaves it alone
  always_ff @(posedge clk) begin
    if (reset) begin
      stat_steer <= 1'b0;
      steer_prev <= 1'b0;
    end else begin
      steer_prev <= rx_steer_delayed;
      if (!rx_steer_delayed && steer_prev)
        stat_steer <= 1'b1;
      else if (rx_steer_delayed && !steer_prev)
        stat_steer <= 1'b0;
    end
  end

  // Receive data register
  logic [3:0] rx_data;

  always_ff @(posedge clk) begin
    if (reset)
      rx_data <= DATA_RESET;
    else if (rx_valid)
      rx_data <= rx_code;
  end

  // Read data captured at cycle start, driven while a read is open
  wire [3:0] status_word = {stat_steer, stat_rxf, stat_txe, stat_irq};

  always_ff @(posedge clk) begin
    if (reset)
      data_out <= DATA_RESET;
    else if (rd_st_beg)
      data_out <= status_word;
    else if (rd_rx_beg)
      data_out <= rx_data;
  end

  assign data_out_enable_n = !(acc_on && acc_rw == DIR_READ);

  // Event pin: diagnostic steering, call progress wave, or interrupt
  wire next_pin_drive = diag_mode ? rx_steer_delayed :
                        !irq_en   ? 1'b0 :
                        cp_mode   ? !call_progress_tone : stat_irq;
  logic pin_drive;

  always_ff @(posedge clk) begin
    if (reset)
      pin_drive <= 1'b0;
    else
      pin_drive <= next_pin_drive;
  end

  // Open drain: only ever pulls low
  assign event_tone_pin_out  = 1'b0;
  assign event_tone_pin_oe_n = !pin_drive;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_burst_start_tone: assert property (
    (wr_tx && burst_mode && !tmr_busy && primary_control[PC_TONE_OUT]) |=> ##1 tone_on)
    else $error("burst did not start tone");
  a_burst_done_flag: assert property (
    (tmr_done && burst_mode) |=> (stat_txe && stat_irq))
    else $error("pause end did not set empty and interrupt");
  a_nonburst_tone: assert property (
    (!burst_mode && !$past(burst_mode)) |=> tone_on == $past(primary_control[PC_TONE_OUT]))
    else $error("non-burst tone does not follow enable");
  a_diag_pin: assert property (
    (diag_mode && $past(diag_mode)) |-> event_tone_pin_oe_n == !$past(rx_steer_delayed))
    else $error("diagnostic pin not inverted steering");
  a_single_tone: assert property (
    (wr_ctl && redirect_pend) |=> high_group_select == ($past(wr_data[SC_SINGLE]) && $past(wr_data[SC_COLUMN])))
    else $error("column tone not taken from written single and column bits");
  a_txe_nonburst: assert property (
    !burst_mode |=> !stat_txe)
    else $error("empty flag set in non-burst mode");
  a_rx_full: assert property (
    rx_valid |=> stat_rxf && stat_irq && rx_data == $past(rx_code))
    else $error("received data did not set full");
  a_steer_absent: assert property (
    $fell(rx_steer_delayed) |=> stat_steer)
    else $error("tone absence did not set steering flag");
  a_redirect_write: assert property (
    (wr_ctl && redirect_pend) |=> secondary_control == $past(wr_data) && !redirect_pend)
    else $error("redirected write missed secondary control");
  a_read_keeps_event: assert property (
    (rd_st_end && rx_valid) |=> stat_rxf)
    else $error("event during read was lost");
  a_irq_pin: assert property (
    (irq_en && !cp_mode && !diag_mode && stat_irq) |=> !event_tone_pin_oe_n)
    else $error("interrupt not shown on event pin");

  c_burst_done: cover property (tmr_done && burst_mode);
  c_status_read: cover property (rd_st_end && stat_txe);
  c_redirect: cover property (wr_ctl && redirect_pend);
  c_double_burst: cover property (wr_tx && burst_mode && cp_mode);

endmodule // ttcs_top

`default_nettype wire

// ==== testbench/ttcs_host_model.sv ====
/*
  Host processor model on the parallel register port: one bus cycle task.
  Assumes it shares the block clock and that reads are answered by the enable.
*/
`timescale 1ns/100ps
`default_nettype none

module ttcs_host_model
  import ttcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [3:0] data_out,
  input  wire logic       data_out_enable_n,
  output var  logic       chip_select_n,
  output var  logic       register_select_line,
  output var  logic       read_write,
  output var  logic [3:0] data_in
);
  // Idle bus: deselected, pointing at status
  initial begin
    chip_select_n = 1'b1;
    register_select_line = SEL_CONTROL;
    read_write = DIR_READ;
    data_in = 4'h0;
  end

  // One cycle; all lines held until the answer, then past the synchronisers
  task automatic cycle(input logic sel, input logic dir, input logic [3:0] d, output logic [3:0] q);
    int n;
    n = 0;
    @(posedge clk);
    chip_select_n        <= 1'b0;
    register_select_line <= sel;
    read_write           <= dir;
    data_in              <= d;
    repeat (4) @(posedge clk);
    while (dir == DIR_READ && data_out_enable_n !== 1'b0 && n < 8) begin
      @(posedge clk);
      n++;
    end
    // Read data taken at the edge that sees the enable; unknown if it never came
    q = (data_out_enable_n === 1'b0) ? data_out : 4'hX;
    chip_select_n <= 1'b1;
    repeat (3) @(posedge clk);
    // A released bus shows the inverse, never the old value
    data_in              <= ~d;
    register_select_line <= ~sel;
    read_write           <= ~dir;
    repeat (2) @(posedge clk);
  endtask
endmodule // ttcs_host_model

`default_nettype wire

// ==== testbench/test_tone_transceiver_ctrl_status.sv ====
/*
  Self-checking bench of the control and status block against a model of
  status flags and received codes. Assumes the host model drives the bus.
*/
`timescale 1ns/100ps
`default_nettype none

module test_tone_transceiver_ctrl_status;
  import ttcs_pkg::*;
  localparam int BC = 20;
  localparam int LIMIT = 8000;
  logic       clk, reset, rx_valid, rx_steer_delayed, call_progress_tone;
  logic       chip_select_n, register_select_line, read_write;
  logic [3:0] rx_code, data_in, data_out, tx_code, q;
  logic       data_out_enable_n, event_tone_pin_out, event_tone_pin_oe_n;
  logic       tone_on, filter_mode_select, single_tone_select, high_group_select;
  int         num_errors, cmp_count, cycles, run, last_run, exp_status;
  int         rx_q[$];

  ttcs_top #(.BURST_CYCLES(BC)) u_ttcs_top (.clk(clk), .reset(reset), .chip_select_n(chip_select_n),
    .register_select_line(register_select_line), .read_write(read_write), .data_in(data_in),
    .data_out(data_out), .data_out_enable_n(data_out_enable_n), .rx_valid(rx_valid), .rx_code(rx_code),
    .rx_steer_delayed(rx_steer_delayed), .call_progress_tone(call_progress_tone),
    .event_tone_pin_out(event_tone_pin_out), .event_tone_pin_oe_n(event_tone_pin_oe_n),
    .tone_on(tone_on), .tx_code(tx_code), .filter_mode_select(filter_mode_select),
    .single_tone_select(single_tone_select), .high_group_select(high_group_select));

  ttcs_host_model u_host (.clk(clk), .data_out(data_out), .data_out_enable_n(data_out_enable_n),
    .chip_select_n(chip_select_n), .register_select_line(register_select_line),
    .read_write(read_write), .data_in(data_in));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Tone run length, and a ceiling on the whole run
  always @(posedge clk) begin
    run <= tone_on ? run + 1 : 0;
    if (!tone_on && run > 0) last_run <= run;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic sel, input logic [3:0] d);
    u_host.cycle(sel, DIR_WRITE, d, q);
  endtask

  // Expectation taken at the start: the read shows the snapshot
  task automatic rd_st();
    int e;
    e = exp_status;
    u_host.cycle(SEL_CONTROL, DIR_READ, 4'h0, q);
    check(8'(q), 8'(e));
    check(8'(data_out_enable_n), 8'h01);
    exp_status = exp_status & 8;
  endtask

  task automatic rd_rx();
    u_host.cycle(SEL_DATA, DIR_READ, 4'h0, q);
    check(8'(q), 8'(rx_q.pop_front()));
  endtask

  task automatic rx(input logic [3:0] code);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_code  <= code;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_q.push_back(int'(code));
  endtask

  // Burst of len cycles, equal pause, then empty and interrupt flags.
  // The read opens as the pause ends, so a short pause shows up early
  // and the flag raised during the read must survive it.
  task automatic burst(input int len);
    logic [3:0] c;
    c = 4'($urandom);
    wr(SEL_DATA, c);
    check(8'(tx_code), 8'(c));
    repeat (2 * len - 6) @(posedge clk);
    rd_st();
    check(8'(last_run), 8'(len));
    exp_status = exp_status | 3;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    rx_valid = 1'b0;
    rx_code = 4'h0;
    rx_steer_delayed = 1'b1;
    call_progress_tone = 1'b1;
    {num_errors, cmp_count, cycles, run, last_run, exp_status} = '0;
    void'($urandom(32'h0280BAB6));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Software reset sequence
    rd_st();
    wr(SEL_CONTROL, 4'h0);
    wr(SEL_CONTROL, 4'h0);
    wr(SEL_CONTROL, 4'h8);
    wr(SEL_CONTROL, 4'h0);
    rd_st();
    done("init");
    // All tone selections; the write after each goes back to primary
    for (int i = 0; i < 4; i++) begin
      wr(SEL_CONTROL, 4'h8);
      wr(SEL_CONTROL, 4'(i << 2));
      wr(SEL_CONTROL, 4'h2);
      check(8'(single_tone_select), 8'(i & 1));
      check(8'(high_group_select), 8'(i == 3));
      check(8'(filter_mode_select), 8'h01);
    end
    wr(SEL_CONTROL, 4'h8);
    wr(SEL_CONTROL, 4'h0);
    done("tone select");
    // Normal burst with interrupt, then doubled burst in filter mode
    wr(SEL_CONTROL, 4'h5);
    burst(BC);
    check(8'(event_tone_pin_oe_n), 8'h00);
    check(8'(event_tone_pin_out), 8'h00);
    rd_st();
    check(8'(event_tone_pin_oe_n), 8'h01);
    rd_st();
    wr(SEL_CONTROL, 4'h3);
    burst(2 * BC);
    rd_st();
    done("burst");
    // Receive, then an event landing inside an open status read
    wr(SEL_CONTROL, 4'h5);
    rx(4'($urandom));
    exp_status = exp_status | 5;
    repeat (2) @(negedge clk);
    check(8'(event_tone_pin_oe_n), 8'h00);
    rd_st();
    rd_rx();
    // Event just before, then on, the edge that ends the read
    for (int k = 5; k < 7; k++) begin
      fork
        rd_st();
        begin
          repeat (k) @(posedge clk);
          rx(4'($urandom));
        end
      join
      exp_status = exp_status | 5;
      rd_st();
      rd_rx();
    end
    done("receive");
    // Steering flag survives reads
    @(posedge clk);
    rx_steer_delayed <= 1'b0;
    repeat (3) @(posedge clk);
    exp_status = 8;
    rd_st();
    rd_st();
    rx_steer_delayed <= 1'b1;
    repeat (3) @(posedge clk);
    exp_status = 0;
    rd_st();
    done("steering");
    // Untimed tone follows the enable; a pending empty flag is dropped
    burst(BC);
    wr(SEL_CONTROL, 4'h8);
    wr(SEL_CONTROL, 4'h1);
    wr(SEL_CONTROL, 4'h1);
    repeat (2 * BC + 8) @(negedge clk);
    check(8'(tone_on), 8'h01);
    exp_status = exp_status & 13;
    rd_st();
    wr(SEL_CONTROL, 4'h0);
    repeat (3) @(negedge clk);
    check(8'(tone_on), 8'h00);
    done("non-burst");
    // Diagnostic: pin shows inverted steering
    wr(SEL_CONTROL, 4'h8);
    wr(SEL_CONTROL, 4'h3);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      rx_steer_delayed <= 1'(s);
      repeat (3) @(negedge clk);
      check(8'(event_tone_pin_oe_n), 8'(1 - s));
    end
    done("diagnostic");
    tally_and_finish();
  end
endmodule // test_tone_transceiver_ctrl_status

`default_nettype wire
